// *** logic/sswd_pkg.sv ***
`default_nettype none
package sswd_pkg;

  // clock and timebase
  localparam int CLK_MHZ       = 25;
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_CYC      = CLK_MHZ;        // mclk cycles per 1 us tick
  localparam int TICK_W        = 5;

  // supervisory intervals, as printed, and their tick counts
  localparam int  RESET_TIMEOUT_MS = 200;
  localparam int  RESET_TIMEOUT_US = RESET_TIMEOUT_MS * 1000;
  localparam real WD_DEFAULT_S     = 1.6;
  localparam int  WD_DEFAULT_US    = int'(WD_DEFAULT_S * 1.0e6);
  localparam int  PULSE_MS         = 1;
  localparam int  PULSE_US         = PULSE_MS * 1000;
  localparam int  CS_HOLD_US       = 15;
  localparam int  MR_MIN_US        = 25;
  localparam real CAP_MS_PER_NF    = 2.1;
  localparam int  CAP_US_PER_NF    = int'(CAP_MS_PER_NF * 1000.0);
  localparam int  CAP_NF_W         = 7;
  localparam int  TMR_W            = 22;

  // short figures in mclk cycles: least time rounds up, longest down
  localparam int ACT_MIN_NS    = 100;
  localparam int ACT_MIN_CYC   =
    (ACT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FAULT_DLY_NS  = 70;
  localparam int FAULT_DLY_RAW = FAULT_DLY_NS / CLK_PERIOD_NS;
  localparam int FAULT_DLY_CYC = (FAULT_DLY_RAW < 1) ? 1 : FAULT_DLY_RAW;

  // three-level activity input codes; 2'h3 is read as mid-level
  typedef enum logic [1:0] {
    LVL_LOW  = 2'h0,
    LVL_MID  = 2'h1,
    LVL_HIGH = 2'h2
  } sswd_level_e;

  typedef enum logic [2:0] {
    WD_IDLE  = 3'h1,
    WD_RUN   = 3'h2,
    WD_DELAY = 3'h4
  } sswd_wd_e;

  // threshold comparator results, one bit per analog comparison
  typedef struct packed {
    logic supplyOk;   // main supply above reset threshold
    logic warnOk;     // main supply above early-warning threshold
    logic failOk;     // fail sense input above its threshold
    logic onBackup;   // switched supply taken from backup source
  } sswd_cmp_s;

  typedef struct packed {
    logic [TICK_W-1:0] tickCnt;
    logic              tick;
    logic              mrPrev;
    logic              mrQual;
    logic              holdPrev;
    logic              hostResetN;
    logic              useInternal;
    logic [1:0]        actCand;
    logic [1:0]        actStab;
    logic [1:0]        actLast;
    sswd_wd_e          wd;
    logic [1:0]        dlyCnt;
    logic              faultN;
    logic              pulseN;
    logic              csOutN;
    logic              backupOn;
    logic              warnN;
    logic              failN;
    logic              activityTermEn;
  } sswd_state_s;

  localparam sswd_state_s SSWD_STATE_RST = '{
    tickCnt:        '0,
    tick:           1'h0,
    mrPrev:         1'h1,
    mrQual:         1'h0,
    holdPrev:       1'h1,
    hostResetN:     1'h0,
    useInternal:    1'h0,
    actCand:        LVL_MID,
    actStab:        2'h0,
    actLast:        LVL_MID,
    wd:             WD_IDLE,
    dlyCnt:         2'h0,
    faultN:         1'h1,
    pulseN:         1'h1,
    csOutN:         1'h1,
    backupOn:       1'h0,
    warnN:          1'h1,
    failN:          1'h1,
    activityTermEn: 1'h0
  };

endpackage
`default_nettype wire

// *** logic/sswd_timer.sv ***
`timescale 1ns/100ps
`default_nettype none
module sswd_timer #(
  parameter int W = 22
) (
  input  wire logic         mclk,
  input  wire logic         nrst,
  input  wire logic         halt,
  input  wire logic         restart,
  input  wire logic         tick,
  input  wire logic [W-1:0] load,
  output logic              busy,
  output logic              done
);

  typedef struct packed {
    logic [W-1:0] count;
    logic         busy;
    logic         done;
  } sswd_tmr_s;

  sswd_tmr_s st_r;
  sswd_tmr_s st_nxt;

  // countdown in timebase ticks; halt wins over restart
  always_comb begin
    st_nxt      = st_r;
    st_nxt.done = 1'h0;
    if (halt) begin
      st_nxt.count = '0;
      st_nxt.busy  = 1'h0;
    end else if (restart) begin
      st_nxt.count = (load == '0) ? W'(1) : load; // zero load runs one tick
      st_nxt.busy  = 1'h1;
    end else if (st_r.busy && tick) begin
      if (st_r.count <= W'(1)) begin
        st_nxt.count = '0;
        st_nxt.busy  = 1'h0;
        st_nxt.done  = 1'h1;
      end else begin
        st_nxt.count = st_r.count - W'(1);
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign busy = st_r.busy;
  assign done = st_r.done;

endmodule
`default_nettype wire

// *** logic/sswd_supervisor.sv ***
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// (RQ1) reset held low while supply is low, then 200 ms after recovery
// (RQ2) manual reset low holds reset; delay starts when it returns high
// (RQ3) manual reset of 25 us clears counters, faults high, default timeout
// (RQ4) qualified manual reset forces gated chip-select high
// (RQ5) activity idle past timeout raises fault pulse and fault level
// (RQ6) activity change of 100 ns restarts watchdog; host must toggle in time
// (RQ7) timeout ends with fault pulse low for 1 ms then high
// (RQ8) fault output falls just after pulse falls, held until next activity
// (RQ9) mid-level activity input disables watchdog, fault stays high
// (RQ10) supply low disables watchdog, fault high, activity input released
// (RQ11) fault output high whenever reset output is asserted
// (RQ12) timeout select picks internal 1.6 s or 2.1 ms per nF
// (RQ13) chip-select passes low only when supply good; 15 us hold on reset
// (RQ14) backup-active output follows the switchover comparator
// (RQ15) early-warning output low when supply nears reset threshold
// (RQ16) fail flag low while sense input below threshold, nothing else
// (RQ17) switchover never touches reset
// (RQ18) external flip-flop latches reset after two faults in a row
// (RQ19) all intervals counted from the timebase, cleared by reset events; the activity width and fault delay are counted in mclk cycles
module sswd_supervisor #(
  parameter int RESET_US = sswd_pkg::RESET_TIMEOUT_US,
  parameter int WD_US    = sswd_pkg::WD_DEFAULT_US,
  parameter int PULSE_US = sswd_pkg::PULSE_US
) (
  input  wire logic                          mclk,
  input  wire logic                          nrst,
  input  wire sswd_pkg::sswd_cmp_s           cmpIn,
  input  wire logic                          manualResetInN,
  input  wire logic [1:0]                    activityInput,
  input  wire logic                          timeoutSelect,
  input  wire logic [sswd_pkg::CAP_NF_W-1:0] capNf,
  input  wire logic                          chipSelInN,
  output logic                               hostResetN,
  output logic                               faultOutputN,
  output logic                               faultPulseOutputN,
  output logic                               chipSelOutN,
  output logic                               backupActiveOutput,
  output logic                               earlySupplyWarningN,
  output logic                               failFlagOutputN,
  output logic                               activityTermEn
);

  localparam int W = sswd_pkg::TMR_W;

  sswd_pkg::sswd_state_s st_r;
  sswd_pkg::sswd_state_s st_nxt;

  logic         resetHold;
  logic         actEvent;
  logic         wdOn;
  logic [1:0]   lvl;
  logic [W-1:0] wdLoad;
  logic         mrHalt,    mrStart,    mrDone;
  logic         rstHalt,   rstStart,   rstDone;
  logic         wdHalt,    wdStart,    wdDone;
  logic         pulseHalt, pulseStart, pulseBusy, pulseDone;
  logic         holdHalt,  holdStart,  holdBusy,  holdDone;

  // the five interval counters share one parameterised timer
  sswd_timer #(.W(W)) mrTmr (
    .mclk    (mclk),
    .nrst    (nrst),
    .halt    (mrHalt),
    .restart (mrStart),
    .tick    (st_r.tick),
    .load    (W'(sswd_pkg::MR_MIN_US)),
    .busy    (),
    .done    (mrDone)
  );

  // one spare tick: the first tick after a load is only partial, so the
  // host delay may run long by up to a tick but never short
  sswd_timer #(.W(W)) rstTmr (
    .mclk    (mclk),
    .nrst    (nrst),
    .halt    (rstHalt),
    .restart (rstStart),
    .tick    (st_r.tick),
    .load    (W'(RESET_US + 1)),
    .busy    (),
    .done    (rstDone)
  );

  sswd_timer #(.W(W)) wdTmr (
    .mclk    (mclk),
    .nrst    (nrst),
    .halt    (wdHalt),
    .restart (wdStart),
    .tick    (st_r.tick),
    .load    (wdLoad),
    .busy    (),
    .done    (wdDone)
  );

  sswd_timer #(.W(W)) pulseTmr (
    .mclk    (mclk),
    .nrst    (nrst),
    .halt    (pulseHalt),
    .restart (pulseStart),
    .tick    (st_r.tick),
    .load    (W'(PULSE_US)),
    .busy    (pulseBusy),
    .done    (pulseDone)
  );

  sswd_timer #(.W(W)) holdTmr (
    .mclk    (mclk),
    .nrst    (nrst),
    .halt    (holdHalt),
    .restart (holdStart),
    .tick    (st_r.tick),
    .load    (W'(sswd_pkg::CS_HOLD_US)),
    .busy    (holdBusy),
    .done    (holdDone)
  );

  // whole supervisor next state
  always_comb begin
    st_nxt     = st_r;
    actEvent   = 1'h0;
    wdStart    = 1'h0;
    pulseStart = 1'h0;

    // free-running 1 us timebase
    if (st_r.tickCnt == sswd_pkg::TICK_W'(sswd_pkg::TICK_CYC - 1)) begin
      st_nxt.tickCnt = '0;
      st_nxt.tick    = 1'h1; // RQ19
    end else begin
      st_nxt.tickCnt = st_r.tickCnt + sswd_pkg::TICK_W'(1);
      st_nxt.tick    = 1'h0;
    end

    // manual reset width qualification; a short glitch only resets the host
    mrHalt        = manualResetInN;
    mrStart       = !manualResetInN && st_r.mrPrev;
    st_nxt.mrPrev = manualResetInN;
    if (manualResetInN) begin
      st_nxt.mrQual = 1'h0;
    end else if (mrDone) begin
      st_nxt.mrQual = 1'h1; // RQ3
    end

    // host reset: supply and manual input only, switchover not consulted
    resetHold       = !cmpIn.supplyOk || !manualResetInN; // RQ1 RQ2 RQ17
    rstHalt         = resetHold;
    rstStart        = !resetHold && st_r.holdPrev; // RQ2
    st_nxt.holdPrev = resetHold;
    st_nxt.hostResetN = !resetHold && !rstStart &&
                        (st_r.hostResetN || rstDone); // RQ1

    // activity input must hold a new level for the least change width
    lvl = (activityInput == 2'h3) ? sswd_pkg::LVL_MID : activityInput;
    if (lvl != st_r.actCand) begin
      st_nxt.actCand = lvl;
      st_nxt.actStab = 2'h0;
    end else if (st_r.actStab != 2'(sswd_pkg::ACT_MIN_CYC - 1)) begin
      st_nxt.actStab = st_r.actStab + 2'h1;
    end else if (st_r.actCand != st_r.actLast && cmpIn.supplyOk) begin
      st_nxt.actLast = st_r.actCand;
      actEvent       = 1'h1; // RQ6
    end

    // watchdog runs only with reset released, supply good, input driven
    wdOn = st_nxt.hostResetN && cmpIn.supplyOk && !st_nxt.mrQual &&
           st_nxt.actLast != sswd_pkg::LVL_MID; // RQ9 RQ10 RQ11

    // timeout choice; a qualified manual reset pins the internal default
    if (st_nxt.mrQual) begin
      st_nxt.useInternal = 1'h1; // RQ3
    end
    if (st_r.useInternal || timeoutSelect) begin
      wdLoad = W'(WD_US); // RQ12
    end else begin
      wdLoad = W'(capNf) * W'(sswd_pkg::CAP_US_PER_NF); // RQ12
    end

    wdHalt    = !wdOn; // RQ19
    pulseHalt = !wdOn;

    // watchdog sequencer: timeout, pulse, delayed fault level
    unique case (st_r.wd)
      sswd_pkg::WD_IDLE: begin
        if (wdOn) begin
          wdStart   = 1'h1;
          st_nxt.wd = sswd_pkg::WD_RUN;
        end
      end
      sswd_pkg::WD_RUN: begin
        if (!wdOn) begin
          st_nxt.wd = sswd_pkg::WD_IDLE;
        end else if (actEvent) begin
          wdStart       = 1'h1; // RQ6
          st_nxt.faultN = 1'h1; // RQ8
        end else if (wdDone) begin
          wdStart       = 1'h1; // second fault needs another full period
          pulseStart    = 1'h1; // RQ5 RQ7
          st_nxt.pulseN = 1'h0; // RQ5 RQ7
          st_nxt.dlyCnt = 2'(sswd_pkg::FAULT_DLY_CYC - 1);
          st_nxt.wd     = sswd_pkg::WD_DELAY;
        end
      end
      sswd_pkg::WD_DELAY: begin
        if (!wdOn) begin
          st_nxt.wd = sswd_pkg::WD_IDLE;
        end else if (actEvent) begin
          wdStart       = 1'h1;
          st_nxt.faultN = 1'h1; // RQ8
          st_nxt.wd     = sswd_pkg::WD_RUN;
        end else if (st_r.dlyCnt == 2'h0) begin
          st_nxt.faultN = 1'h0; // RQ5 RQ8
          st_nxt.wd     = sswd_pkg::WD_RUN;
        end else begin
          st_nxt.dlyCnt = st_r.dlyCnt - 2'h1;
        end
      end
      default: begin
        st_nxt.wd = sswd_pkg::WD_IDLE;
      end
    endcase

    // pulse ends on its own timer, fault level stays for the host flop
    if (pulseDone) begin
      st_nxt.pulseN = 1'h1; // RQ7
    end
    if (!wdOn) begin
      st_nxt.faultN = 1'h1; // RQ3 RQ9 RQ10 RQ11
      st_nxt.pulseN = 1'h1; // RQ3
    end

    // chip-select gate; the hold lets a memory cycle in flight finish
    holdStart = st_r.hostResetN && !st_nxt.hostResetN && !chipSelInN &&
                !st_nxt.mrQual; // RQ13
    holdHalt  = st_nxt.mrQual || chipSelInN; // RQ4 RQ13
    if (st_nxt.mrQual) begin
      st_nxt.csOutN = 1'h1; // RQ4
    end else if (st_nxt.hostResetN) begin
      st_nxt.csOutN = chipSelInN; // RQ13
    end else begin
      st_nxt.csOutN = !((holdStart || holdBusy) && !chipSelInN); // RQ13
    end

    // comparator results passed through, each on its own
    st_nxt.backupOn       = cmpIn.onBackup; // RQ14
    st_nxt.warnN          = cmpIn.warnOk;   // RQ15
    st_nxt.failN          = cmpIn.failOk;   // RQ16
    st_nxt.activityTermEn = cmpIn.supplyOk; // RQ10
  end

  // async reset is the power-on condition
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_r <= sswd_pkg::SSWD_STATE_RST; // RQ19
    end else begin
      st_r <= st_nxt;
    end
  end

  // every output straight from the state register
  assign hostResetN          = st_r.hostResetN;
  assign faultOutputN        = st_r.faultN;
  assign faultPulseOutputN   = st_r.pulseN;
  assign chipSelOutN         = st_r.csOutN;
  assign backupActiveOutput  = st_r.backupOn;
  assign earlySupplyWarningN = st_r.warnN;
  assign failFlagOutputN     = st_r.failN;
  assign activityTermEn      = st_r.activityTermEn;

  // checks on the supervisor's own outputs
  default clocking sswdCk @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  sequence pulseFall_s;
    $fell(st_r.pulseN);
  endsequence

  sequence quietOn_s;
    !actEvent && wdOn;
  endsequence

  reset_supply_a: assert property ( // RQ1
    !cmpIn.supplyOk |=> !st_r.hostResetN)
    else $error("reset not low during supply fault");

  reset_delay_a: assert property ( // RQ1
    $fell(resetHold) |=> !st_r.hostResetN [*8])
    else $error("reset released before timeout");

  reset_manual_a: assert property ( // RQ2
    !manualResetInN |=> !st_r.hostResetN)
    else $error("reset not held by manual input");

  mr_clear_a: assert property ( // RQ3
    st_r.mrQual |-> st_r.faultN && st_r.pulseN && st_r.useInternal)
    else $error("manual reset did not clear watchdog");

  cs_manual_a: assert property ( // RQ4
    st_r.mrQual |-> st_r.csOutN)
    else $error("chip-select not forced high");

  act_restart_a: assert property ( // RQ6
    actEvent && wdOn |=> st_r.faultN && st_r.wd == sswd_pkg::WD_RUN)
    else $error("activity did not restart watchdog");

  pulse_state_a: assert property ( // RQ7
    pulseFall_s |-> st_r.wd == sswd_pkg::WD_DELAY && pulseBusy)
    else $error("pulse fell outside timeout");

  fault_delay_a: assert property ( // RQ8
    pulseFall_s ##0 quietOn_s |=> !st_r.faultN)
    else $error("fault level missed after pulse");

  mid_disable_a: assert property ( // RQ9
    st_r.actLast == sswd_pkg::LVL_MID |-> st_r.faultN && st_r.pulseN)
    else $error("fault low with input floating");

  supply_off_a: assert property ( // RQ10
    !st_r.activityTermEn |-> st_r.faultN)
    else $error("fault low with supply down");

  fault_reset_a: assert property ( // RQ11
    !st_r.hostResetN |-> st_r.faultN)
    else $error("fault low during reset");

  cs_follow_a: assert property ( // RQ13
    !st_r.csOutN && !st_r.hostResetN |-> !$past(chipSelInN))
    else $error("chip-select low without low input");

  cs_pass_a: assert property ( // RQ13
    st_r.hostResetN && !st_r.mrQual |-> st_r.csOutN == $past(chipSelInN))
    else $error("chip-select not passed through");

  backup_indep_a: assert property ( // RQ17
    $changed(cmpIn.onBackup) && cmpIn.supplyOk && manualResetInN &&
    st_r.hostResetN
    |=> st_r.hostResetN)
    else $error("switchover disturbed reset");

endmodule
`default_nettype wire

// *** verification/sswd_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// host cpu side: drives the activity line and an external shutdown flop
module sswd_host_model (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        hostResetN,
  input  wire logic        faultOutputN,
  input  wire logic        faultPulseOutputN,
  input  wire logic        floatLine,
  input  wire logic [15:0] kickPeriod,
  output logic [1:0]       activityInput,
  output logic             shutdownQ
);
  logic actLvl = 1'h0;
  int   kickCnt = 0;

  // an unconnected pin sits at mid-level
  assign activityInput = floatLine ? 2'h1 : {actLvl, 1'h0};

  // one manual kick, called just after a falling edge
  task automatic flip();
    actLvl = ~actLvl;
  endtask

  // a running host kicks; period kept far above the 3-cycle minimum
  always @(negedge mclk) begin
    if (!hostResetN || kickPeriod == 16'h0000) begin
      kickCnt <= 0;
    end else if (kickCnt >= int'(kickPeriod) - 1) begin
      kickCnt <= 0;
      actLvl  <= ~actLvl;
    end else begin
      kickCnt <= kickCnt + 1;
    end
  end

  // two faults with no kick between them latch the system down
  always @(negedge faultPulseOutputN or negedge nrst) begin
    if (!nrst) begin
      shutdownQ <= 1'h1;
    end else begin
      shutdownQ <= faultOutputN;
    end
  end
endmodule
`default_nettype wire

// *** verification/supply_supervisor_watchdog_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module supply_supervisor_watchdog_tb;
  localparam int RST = 20;
  localparam int WD  = 50;
  localparam int PUL = 5;
  localparam int TK  = sswd_pkg::TICK_CYC;
  localparam int LIMIT = 40000;

  logic                mclk = 1'h0;
  logic                nrst;
  sswd_pkg::sswd_cmp_s cmpIn;
  logic                manualResetInN;
  logic [1:0]          activityInput;
  logic                timeoutSelect;
  logic [6:0]          capNf;
  logic                chipSelInN;
  logic                hostResetN;
  logic                faultOutputN;
  logic                faultPulseOutputN;
  logic                chipSelOutN;
  logic                backupActiveOutput;
  logic                earlySupplyWarningN;
  logic                failFlagOutputN;
  logic                activityTermEn;
  logic                floatLine;
  logic [15:0]         kickPeriod;
  logic                shutdownQ;
  int                  fails = 0;
  int                  compares = 0;
  int                  cycles = 0;
  int                  pulseFalls = 0;
  int                  n;
  int                  p0;

  always #20 mclk = ~mclk;

  sswd_supervisor #(.RESET_US(RST), .WD_US(WD), .PULSE_US(PUL)) DUT (
    .mclk(mclk), .nrst(nrst), .cmpIn(cmpIn),
    .manualResetInN(manualResetInN), .activityInput(activityInput),
    .timeoutSelect(timeoutSelect), .capNf(capNf),
    .chipSelInN(chipSelInN), .hostResetN(hostResetN),
    .faultOutputN(faultOutputN), .faultPulseOutputN(faultPulseOutputN),
    .chipSelOutN(chipSelOutN), .backupActiveOutput(backupActiveOutput),
    .earlySupplyWarningN(earlySupplyWarningN),
    .failFlagOutputN(failFlagOutputN), .activityTermEn(activityTermEn)
  );

  sswd_host_model host (
    .mclk(mclk), .nrst(nrst), .hostResetN(hostResetN),
    .faultOutputN(faultOutputN), .faultPulseOutputN(faultPulseOutputN),
    .floatLine(floatLine), .kickPeriod(kickPeriod),
    .activityInput(activityInput), .shutdownQ(shutdownQ)
  );

  // fault pulses seen so far; quiet spans compare this count
  always @(negedge faultPulseOutputN) pulseFalls++;

  task automatic check(input logic got, input logic exp, input string what);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %s", $time, what);
    end
  endtask

  task automatic inRange(input int v, input int lo, input int hi,
                         input string what);
    compares++;
    if (v < lo || v > hi) begin
      fails++;
      $display("[ERR] %0t %s took %0d", $time, what, v);
    end
  endtask

  function automatic logic pick(input int idx);
    case (idx)
      0: return hostResetN;
      1: return faultOutputN;
      2: return faultPulseOutputN;
      default: return chipSelOutN;
    endcase
  endfunction

  // bounded wait at falling edges, where outputs have settled
  task automatic waitFor(input int idx, input logic lvl, input int maxCyc,
                         output int cnt);
    cnt = 0;
    while (pick(idx) !== lvl && cnt < maxCyc) begin
      @(negedge mclk);
      cnt++;
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge mclk);
  endtask

  task automatic conclude();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // hang guard, well above the expected run length
  always @(posedge mclk) begin
    cycles++;
    if (cycles >= LIMIT) begin
      fails++;
      conclude();
    end
  end

  initial begin
    nrst = 1'h0;
    cmpIn = '{1'h1, 1'h1, 1'h1, 1'h0};
    manualResetInN = 1'h1;
    timeoutSelect = 1'h1;
    capNf = 7'h01;
    chipSelInN = 1'h1;
    floatLine = 1'h1;
    kickPeriod = 16'h0000;
    cyc(3);
    check(hostResetN, 1'h0, "reset held in reset");
    check(faultOutputN, 1'h1, "fault high in reset");
    nrst = 1'h1;
    waitFor(0, 1'h1, 2 * RST * TK, n);
    inRange(n, RST * TK, (RST + 1) * TK + 4, "power-up delay");
    // the backup, fail and warning comparators each reach their own output only
    for (int b = 0; b < 3; b++) begin
      cmpIn[b] = ~cmpIn[b];
      cyc(2);
      check(backupActiveOutput, cmpIn.onBackup, "backup flag");
      check(failFlagOutputN, cmpIn.failOk, "fail flag");
      check(earlySupplyWarningN, cmpIn.warnOk, "early warning");
      check(hostResetN, 1'h1, "reset disturbed");
      check(faultOutputN, 1'h1, "fault disturbed");
      cmpIn[b] = ~cmpIn[b];
    end
    for (int k = 0; k < 4; k++) begin
      chipSelInN = ~chipSelInN;
      cyc(1);
      check(chipSelOutN, chipSelInN, "cs pass");
    end
    // steady kicks well inside the period keep the watchdog quiet
    floatLine = 1'h0;
    kickPeriod = 16'(20 * TK);
    p0 = pulseFalls;
    cyc(4 * WD * TK);
    inRange(pulseFalls - p0, 0, 0, "pulse while kicked");
    kickPeriod = 16'h0000;
    cyc(8); // a last periodic kick must qualify before the manual one
    host.flip();
    waitFor(2, 1'h0, (WD + 3) * TK, n);
    inRange(n, (WD - 1) * TK, (WD + 2) * TK, "timeout");
    check(faultOutputN, 1'h1, "fault before pulse");
    cyc(1);
    check(faultOutputN, 1'h0, "fault level");
    waitFor(2, 1'h1, (PUL + 2) * TK, n);
    inRange(n, (PUL - 1) * TK - 1, (PUL + 1) * TK + 2, "pulse width");
    check(shutdownQ, 1'h1, "one fault latched");
    check(faultOutputN, 1'h0, "fault not held");
    waitFor(2, 1'h0, (WD + 3) * TK, n);
    inRange(n, (WD - PUL - 2) * TK, (WD - PUL + 2) * TK, "repeat");
    cyc(1);
    check(shutdownQ, 1'h0, "two faults not latched");
    host.flip();
    waitFor(1, 1'h1, 8, n);
    inRange(n, 1, 6, "fault clear");
    waitFor(2, 1'h1, (PUL + 2) * TK, n);
    // a floating line disables the watchdog
    floatLine = 1'h1;
    p0 = pulseFalls;
    cyc(2 * WD * TK);
    inRange(pulseFalls - p0, 0, 0, "pulse on mid level");
    check(faultOutputN, 1'h1, "fault on mid level");
    // supply loss with a memory cycle open
    floatLine = 1'h0;
    timeoutSelect = 1'h0;
    chipSelInN = 1'h0;
    cyc(2);
    cmpIn.supplyOk = 1'h0;
    cyc(1);
    check(hostResetN, 1'h0, "supply low reset");
    check(activityTermEn, 1'h0, "input not released");
    check(chipSelOutN, 1'h0, "cs not held");
    waitFor(3, 1'h1, 20 * TK, n);
    inRange(n, 13 * TK, 16 * TK + 3, "cs hold");
    p0 = pulseFalls;
    cyc((WD + 5) * TK);
    inRange(pulseFalls - p0, 0, 0, "pulse on low supply");
    check(faultOutputN, 1'h1, "fault on low supply");
    cmpIn.supplyOk = 1'h1;
    waitFor(0, 1'h1, 2 * RST * TK, n);
    inRange(n, RST * TK, (RST + 1) * TK + 4, "recovery delay");
    cyc(1);
    check(activityTermEn, 1'h1, "input still released");
    check(chipSelOutN, 1'h0, "cs not passed");
    // short manual reset; cs input rises before the hold ends
    manualResetInN = 1'h0;
    cyc(2);
    check(hostResetN, 1'h0, "manual reset");
    cyc(5 * TK);
    chipSelInN = 1'h1;
    cyc(1);
    check(chipSelOutN, 1'h1, "cs early rise");
    chipSelInN = 1'h0;
    cyc(4 * TK);
    manualResetInN = 1'h1;
    waitFor(0, 1'h1, 2 * RST * TK, n);
    inRange(n, RST * TK, (RST + 1) * TK + 4, "manual delay");
    p0 = pulseFalls;
    cyc((WD + 5) * TK);
    inRange(pulseFalls - p0, 0, 0, "capacitor timeout");
    // qualified manual reset returns to the internal timeout
    manualResetInN = 1'h0;
    cyc((sswd_pkg::MR_MIN_US + 2) * TK);
    check(chipSelOutN, 1'h1, "cs gated");
    check(hostResetN, 1'h0, "reset held");
    check(faultOutputN, 1'h1, "fault forced");
    check(faultPulseOutputN, 1'h1, "pulse forced");
    manualResetInN = 1'h1;
    waitFor(0, 1'h1, 2 * RST * TK, n);
    inRange(n, RST * TK, (RST + 1) * TK + 4, "qualified delay");
    waitFor(2, 1'h0, (WD + 3) * TK, n);
    inRange(n, (WD - 1) * TK, (WD + 2) * TK, "default timeout");
    conclude();
  end
endmodule
`default_nettype wire
